// ==== design/pin_share_pkg.sv ====
// Package with constants and types for the output pin sharing block
package pin_share_pkg;
  // Configuration number used in place of an illegal one (safe: I2C, nothing on the pins)
  localparam logic [4:0] safe_config     = 5'h01;
  localparam logic [4:0] last_i2c_config = 5'h12;
  localparam logic [4:0] last_config     = 5'h1b;
  // Clock and start window timing
  localparam int unsigned clock_mhz         = 200;
  localparam int unsigned start_window_ms   = 20;
  localparam int unsigned start_window_cyc  =
    start_window_ms * 1000 * clock_mhz;
  // Correction arithmetic width
  localparam int unsigned corr_width = 16;
  // Diagnostic output values
  localparam logic [15:0] diag_high = 16'hffff;
  localparam logic [15:0] diag_low  = 16'h0000;
  // Value sources for a selectable output
  localparam logic [1:0] src_bridge = 2'h0;
  localparam logic [1:0] src_temp1  = 2'h1;
  localparam logic [1:0] src_temp2  = 2'h2;
  localparam logic [1:0] src_alarm  = 2'h3;

  typedef enum {
    st_wait_clear,
    st_load,
    st_check,
    st_one_wire,
    st_run,
    st_diag
  } phase_t;

  typedef enum {
    out_off,
    out_analog,
    out_pwm
  } main_mode_t;
endpackage : pin_share_pkg

// ==== design/output_pin_sharing_and_safety.sv ====
// Output pin assignment, correction and safety supervision logic
//
// Overview of operation
// - At start-up the stored configuration is checked against a signature before measurement runs.
// - The control core registers carry a parity bit that is checked on every cycle while running.
// - A signature or parity fault sets the core error flag, forces active analog, pulse and alarm outputs to a diagnostic value and releases the data pin.
// - Every measurement signal gets a 16-bit correction using stored coefficients and a fixed algorithm.
// - The correction has sensor terms up to third order and temperature terms of first and second order.
// - Control starts after power-on clear, from the internal or the external clock.
// - In I2C mode data is two-way, the main pin is analog, second pulse output or off, pin one is first alarm, first pulse or off, pin two is second alarm or off.
// - In SPI mode pin two is slave select in, pin one is serial data out and the data pin is serial data in.
// - In SPI mode the second alarm never appears and pin one may also carry the first alarm or first pulse output.
// - Alarms come only from the bridge measurement, never from a temperature.
// - A selectable output carries the bridge, first temperature, second temperature or alarm value.
// - After power-on the interface stays in one-wire mode for about 20 ms, then goes to I2C or SPI unless a request came.
// - When pulse output and SPI share pin one, serial traffic wins and interrupts the pulse output.
module output_pin_sharing_and_safety
  import pin_share_pkg::*;
#(
  parameter int unsigned start_window = start_window_cyc
) (
  // Clock and reset
  input  wire logic        core_clk_in,
  input  wire logic        rst_in,
  // Start-up and stored configuration
  input  wire logic        power_on_clear_in,
  input  wire logic        use_ext_clock_in,
  input  wire logic        ext_clock_ok_in,
  input  wire logic [4:0]  pin_config_in,
  input  wire logic [1:0]  main_source_in,
  input  wire logic [1:0]  pin_one_source_in,
  input  wire logic        start_window_en_in,
  input  wire logic [15:0] stored_signature_in,
  input  wire logic [15:0] config_checksum_in,
  input  wire logic        high_diag_in,
  // Calibration coefficients (offset, gain, 2nd, 3rd, temp 1st, temp 2nd)
  input  wire logic [15:0] coef_offset_in,
  input  wire logic [15:0] coef_gain_in,
  input  wire logic [15:0] coef_sq_in,
  input  wire logic [15:0] coef_cube_in,
  input  wire logic [15:0] coef_t1_in,
  input  wire logic [15:0] coef_t2_in,
  // Raw measurements and alarm thresholds
  input  wire logic [15:0] bridge_raw_in,
  input  wire logic [15:0] temp1_raw_in,
  input  wire logic [15:0] temp2_raw_in,
  input  wire logic        sample_valid_in,
  input  wire logic [15:0] alarm_one_level_in,
  input  wire logic [15:0] alarm_two_level_in,
  // Pins and serial interface
  input  wire logic        one_wire_request_in,
  input  wire logic        shared_pin_two_in,
  input  wire logic        serial_data_pin_in,
  input  wire logic        spi_data_out_in,
  input  wire logic        spi_active_in,
  input  wire logic        i2c_data_out_in,
  input  wire logic        i2c_data_oe_in,
  input  wire logic        first_pulse_width_output_in,
  input  wire logic        second_pulse_width_output_in,
  // Pin drive
  output logic             shared_pin_one_out,
  output logic             shared_pin_one_oe_out,
  output logic             shared_pin_two_out,
  output logic             shared_pin_two_oe_out,
  output logic             serial_data_pin_out,
  output logic             serial_data_pin_oe_out,
  output logic             main_pin_pulse_out,
  output logic [15:0]      main_analog_out,
  output logic             main_analog_en_out,
  // Serial side and status
  output logic             spi_select_out,
  output logic             spi_data_in_out,
  output logic             spi_mode_out,
  output logic             one_wire_mode_out,
  output logic [15:0]      pin_one_value_out,
  output logic             core_error_out,
  output logic             running_out
);
  typedef struct packed {
    phase_t      phase;
    logic [31:0] timer;
    logic [4:0]  cfg;
    logic        spi;
    main_mode_t  main_mode;
    logic [1:0]  pin_one_mode;    // 0 off, 1 alarm, 2 pulse
    logic        pin_two_alarm;
    logic [1:0]  main_src;
    logic [1:0]  one_src;
    logic [15:0] bridge;
    logic [15:0] temp1;
    logic [15:0] temp2;
    logic        core_parity;
    logic        alarm_one;
    logic        alarm_two;
    logic        error;
    logic        ss_meta;
    logic        ss_sync;
    logic        sdi_meta;
    logic        sdi_sync;
    logic        pin_one;
    logic        pin_one_oe;
    logic        pin_two;
    logic        pin_two_oe;
    logic        sda;
    logic        sda_oe;
    logic        main_pulse;
    logic [15:0] main_val;
    logic        main_en;
    logic [15:0] one_val;
    logic        spi_on;
    logic        one_wire;
    logic        running;
  } state_t;
  state_t cur;
  state_t next_cur;
  // Parity over the configuration held by the control core
  function automatic logic core_par(input state_t s);
    core_par = ^{s.cfg, s.spi, s.pin_one_mode, s.pin_two_alarm,
                 s.main_src, s.one_src};
  endfunction : core_par
  // Correction: offset, gain, square, cube, temperature terms
  function automatic logic [15:0] correct(
    input logic [15:0] x,
    input logic [15:0] t
  );
    logic [31:0] x2;
    logic [31:0] x3;
    logic [31:0] t2;
    logic [47:0] acc;
    x2  = 32'(x) * 32'(x);
    x3  = 32'(x2[31:16]) * 32'(x);
    t2  = 32'(t) * 32'(t);
    acc = 48'(coef_offset_in) << 16;
    acc = acc + 48'(coef_gain_in) * 48'(x);
    acc = acc + 48'(coef_sq_in) * 48'(x2[31:16]);
    acc = acc + 48'(coef_cube_in) * 48'(x3[31:16]);
    acc = acc + 48'(coef_t1_in) * 48'(t);
    acc = acc + 48'(coef_t2_in) * 48'(t2[31:16]);
    correct = acc[31:16];
  endfunction : correct
  // Value chosen for a selectable output
  function automatic logic [15:0] pick(input logic [1:0] src,
                                       input state_t s);
    case (src)
      src_bridge: pick = s.bridge;
      src_temp1:  pick = s.temp1;
      src_temp2:  pick = s.temp2;
      default:    pick = {16{s.alarm_one}};
    endcase
  endfunction : pick
  // Next state
  always_comb begin
    logic [4:0]  c;
    logic [15:0] diag;
    c    = 5'h00;
    diag = high_diag_in ? diag_high : diag_low;
    next_cur = cur;
    next_cur.ss_meta  = shared_pin_two_in;
    next_cur.ss_sync  = cur.ss_meta;
    next_cur.sdi_meta = serial_data_pin_in;
    next_cur.sdi_sync = cur.sdi_meta;
    case (cur.phase)
      st_wait_clear: begin
        // Start once power-on clear is over and a clock is there
        if (!power_on_clear_in && (!use_ext_clock_in || ext_clock_ok_in)) begin
          next_cur.phase = st_load;
        end
      end
      st_load: begin
        c = pin_config_in;
        if (c == 5'h00 || c > last_config) begin
          c = safe_config;
        end
        c = c - 5'h01;
        next_cur.cfg = c + 5'h01;
        next_cur.spi = (c > (last_i2c_config - 5'h01));
        if (!next_cur.spi) begin
          // Six pin choices per main pin mode
          next_cur.main_mode     = main_mode_t'(32'(c) / 6);
          next_cur.pin_one_mode  = (32'(c) % 6 >= 4) ? 2'h2 :
                                   ((32'(c) % 2 == 1) ? 2'h1 : 2'h0);
          next_cur.pin_two_alarm = (32'(c) % 6 == 2) ||
                                   (32'(c) % 6 == 3) ||
                                   (32'(c) % 6 == 5);
        end else begin
          c = c - last_i2c_config;
          next_cur.main_mode     = main_mode_t'(32'(c) / 3);
          next_cur.pin_one_mode  = 2'(32'(c) % 3);
          next_cur.pin_two_alarm = 1'b0;
        end
        next_cur.main_src = main_source_in;
        next_cur.one_src  = pin_one_source_in;
        next_cur.phase    = st_check;
      end
      st_check: begin
        next_cur.core_parity = core_par(cur);
        if (stored_signature_in != config_checksum_in) begin
          next_cur.error = 1'b1;
          next_cur.phase = st_diag;
        end else begin
          next_cur.timer = 32'h00000000;
          next_cur.phase = start_window_en_in ? st_one_wire : st_run;
        end
      end
      st_one_wire: begin
        // Leave one-wire mode only if no request came in time
        if (one_wire_request_in) begin
          next_cur.timer = 32'(start_window);
        end else if (cur.timer < 32'(start_window - 1)) begin
          next_cur.timer = cur.timer + 32'h00000001;
        end else if (cur.timer == 32'(start_window - 1)) begin
          next_cur.phase = st_run;
        end
      end
      st_run: begin
        if (core_par(cur) != cur.core_parity) begin
          next_cur.error = 1'b1;
          next_cur.phase = st_diag;
        end
      end
      default: begin
        next_cur.error = 1'b1;
      end
    endcase
    // Corrected samples and bridge-only alarms
    if (sample_valid_in && cur.phase == st_run) begin
      next_cur.bridge    = correct(bridge_raw_in, temp1_raw_in);
      next_cur.temp1     = correct(temp1_raw_in, 16'h0000);
      next_cur.temp2     = correct(temp2_raw_in, 16'h0000);
      next_cur.alarm_one = next_cur.bridge > alarm_one_level_in;
      next_cur.alarm_two = next_cur.bridge > alarm_two_level_in;
    end
    // Pin drive from the decoded assignment
    next_cur.main_en    = (cur.phase == st_run) &&
                          cur.main_mode == out_analog;
    next_cur.main_val   = pick(cur.main_src, cur);
    next_cur.main_pulse = (cur.phase == st_run) &&
                          cur.main_mode == out_pwm &&
                          second_pulse_width_output_in;
    next_cur.one_val    = pick(cur.one_src, cur);
    next_cur.pin_one_oe = (cur.phase == st_run) &&
                          (cur.spi || cur.pin_one_mode != 2'h0);
    next_cur.pin_one    = (cur.pin_one_mode == 2'h1) ? cur.alarm_one :
                          first_pulse_width_output_in;
    if (cur.spi && (spi_active_in || cur.pin_one_mode == 2'h0)) begin
      next_cur.pin_one = spi_data_out_in;
    end
    next_cur.pin_two_oe = (cur.phase == st_run) && cur.pin_two_alarm;
    next_cur.pin_two    = cur.alarm_two;
    next_cur.sda_oe     = (cur.phase == st_run) && !cur.spi &&
                          i2c_data_oe_in;
    next_cur.sda        = i2c_data_out_in;
    // Diagnostic values on active analog, pulse and alarm outputs; serial data pin released
    if (cur.phase == st_diag) begin
      next_cur.main_en    = cur.main_mode == out_analog;
      next_cur.main_val   = diag;
      next_cur.main_pulse = (cur.main_mode == out_pwm) && high_diag_in;
      next_cur.pin_one_oe = cur.pin_one_mode != 2'h0;
      next_cur.pin_one    = high_diag_in;
      next_cur.pin_two_oe = cur.pin_two_alarm;
      next_cur.pin_two    = high_diag_in;
      next_cur.one_val    = diag;
      next_cur.sda_oe     = 1'b0;
    end
    // Status flags from the next phase; no serial mode in the window
    next_cur.running  = next_cur.phase == st_run;
    next_cur.one_wire = next_cur.phase == st_one_wire;
    next_cur.spi_on   = next_cur.spi && next_cur.phase != st_one_wire;
  end
  // State register
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end
  // Outputs straight from the state register
  assign shared_pin_one_out     = cur.pin_one;
  assign shared_pin_one_oe_out  = cur.pin_one_oe;
  assign shared_pin_two_out     = cur.pin_two;
  assign shared_pin_two_oe_out  = cur.pin_two_oe;
  assign serial_data_pin_out    = cur.sda;
  assign serial_data_pin_oe_out = cur.sda_oe;
  assign main_pin_pulse_out     = cur.main_pulse;
  assign main_analog_out        = cur.main_val;
  assign main_analog_en_out     = cur.main_en;
  assign spi_select_out         = cur.ss_sync;
  assign spi_data_in_out        = cur.sdi_sync;
  assign spi_mode_out           = cur.spi_on;
  assign one_wire_mode_out      = cur.one_wire;
  assign pin_one_value_out      = cur.one_val;
  assign core_error_out         = cur.error;
  assign running_out            = cur.running;
endmodule : output_pin_sharing_and_safety

// ==== tb/pin_share_properties.sv ====
// Concurrent checks on the ports of the output pin sharing block
module pin_share_properties
  import pin_share_pkg::*;
(
  input wire logic        core_clk_in,
  input wire logic        rst_in,
  input wire logic        power_on_clear_in,
  input wire logic        high_diag_in,
  input wire logic        spi_active_in,
  input wire logic        spi_data_out_in,
  input wire logic        shared_pin_one_out,
  input wire logic        shared_pin_two_oe_out,
  input wire logic        serial_data_pin_oe_out,
  input wire logic [15:0] main_analog_out,
  input wire logic        main_analog_en_out,
  input wire logic        spi_mode_out,
  input wire logic        one_wire_mode_out,
  input wire logic        core_error_out,
  input wire logic        running_out
);
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (rst_in);
  // Pin sharing in serial peripheral mode
  a_spi_no_second_threshold_flag: assert property (
    spi_mode_out |-> !shared_pin_two_oe_out)
    else $error("pin two driven in spi mode");
  a_spi_data_in: assert property (
    spi_mode_out |-> !serial_data_pin_oe_out)
    else $error("data pin driven in spi mode");
  a_spi_priority: assert property (
    running_out && $past(running_out) && spi_mode_out && $past(spi_active_in)
    |-> shared_pin_one_out == $past(spi_data_out_in))
    else $error("pin one lost serial data");
  // Error handling and start-up order
  a_error_sticky: assert property (
    core_error_out |=> core_error_out)
    else $error("error flag dropped");
  a_diag_value: assert property (
    core_error_out ##1 main_analog_en_out
    |-> main_analog_out == (high_diag_in ? diag_high : diag_low))
    else $error("analog output not at diagnostic level");
  a_no_run_error: assert property (
    running_out |-> !core_error_out)
    else $error("running with error set");
  a_run_after_clear: assert property (
    $rose(running_out) |-> $past(power_on_clear_in, 3) == 1'b0)
    else $error("running before clear ended");
  a_one_wire_excl: assert property (
    one_wire_mode_out |-> !spi_mode_out && !running_out)
    else $error("one wire mode overlaps other mode");
  // Main scenarios reached
  c_run: cover property ($rose(running_out));
  c_error: cover property ($rose(core_error_out));
  c_window: cover property (one_wire_mode_out ##1 running_out);
  c_spi: cover property (spi_mode_out && spi_active_in);
endmodule : pin_share_properties

// ==== tb/host_master_model.sv ====
// Host side model driving slave select and serial data into the block
module host_master_model (
  input  wire logic       core_clk_in,
  input  wire logic       frame_in,
  input  wire logic [7:0] byte_in,
  output logic            select_n_out,
  output logic            sdi_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] bit_idx = 3'h7;
  logic       last_bit = 1'b0;
  initial select_n_out = 1'b1;
  initial sdi_out = 1'b0;
  // Shift msb first while selected; released line shows inverse of last bit
  always @(negedge core_clk_in) begin
    select_n_out <= !frame_in;
    if (frame_in) begin
      sdi_out  <= byte_in[bit_idx];
      last_bit <= byte_in[bit_idx];
      bit_idx  <= bit_idx - 3'h1;
    end else begin
      sdi_out <= !last_bit;
      bit_idx <= 3'h7;
    end
  end
endmodule : host_master_model

// ==== tb/output_pin_sharing_and_safety_tb.sv ====
// Self-checking bench for the output pin sharing and safety block
module output_pin_sharing_and_safety_tb;
  import pin_share_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic [3:0] sel; logic [15:0] val;} note_t;
  note_t notes[$];
  note_t cur;
  event look;
  int err_total, samples_checked;
  logic [3:0] pe;
  logic pw;
  logic [15:0] ev [4];
  logic frame, core_clk_in, rst_in, power_on_clear_in, use_ext_clock_in;
  logic ext_clock_ok_in, start_window_en_in, high_diag_in, sample_valid_in;
  logic one_wire_request_in, shared_pin_two_in, serial_data_pin_in;
  logic spi_data_out_in, spi_active_in, i2c_data_out_in, i2c_data_oe_in;
  logic first_pulse_width_output_in, second_pulse_width_output_in;
  logic [4:0] pin_config_in;
  logic [1:0] main_source_in, pin_one_source_in;
  logic [15:0] stored_signature_in, config_checksum_in, coef_offset_in;
  logic [15:0] coef_gain_in, coef_sq_in, coef_cube_in, coef_t1_in;
  logic [15:0] coef_t2_in, bridge_raw_in, temp1_raw_in, temp2_raw_in;
  logic [15:0] alarm_one_level_in, alarm_two_level_in, byte_val;
  logic shared_pin_one_out, shared_pin_one_oe_out, shared_pin_two_out;
  logic shared_pin_two_oe_out, serial_data_pin_out, serial_data_pin_oe_out;
  logic main_pin_pulse_out, main_analog_en_out, spi_select_out;
  logic spi_data_in_out, spi_mode_out, one_wire_mode_out, core_error_out;
  logic running_out;
  logic [15:0] main_analog_out, pin_one_value_out;

  output_pin_sharing_and_safety #(.start_window(10)) dut_u (
    .core_clk_in, .rst_in, .power_on_clear_in, .use_ext_clock_in,
    .ext_clock_ok_in, .pin_config_in, .main_source_in, .pin_one_source_in,
    .start_window_en_in, .stored_signature_in, .config_checksum_in,
    .high_diag_in, .coef_offset_in, .coef_gain_in, .coef_sq_in,
    .coef_cube_in, .coef_t1_in, .coef_t2_in, .bridge_raw_in, .temp1_raw_in,
    .temp2_raw_in, .sample_valid_in, .alarm_one_level_in,
    .alarm_two_level_in, .one_wire_request_in, .shared_pin_two_in,
    .serial_data_pin_in, .spi_data_out_in, .spi_active_in,
    .i2c_data_out_in, .i2c_data_oe_in, .first_pulse_width_output_in,
    .second_pulse_width_output_in, .shared_pin_one_out,
    .shared_pin_one_oe_out, .shared_pin_two_out, .shared_pin_two_oe_out,
    .serial_data_pin_out, .serial_data_pin_oe_out, .main_pin_pulse_out,
    .main_analog_out, .main_analog_en_out, .spi_select_out,
    .spi_data_in_out, .spi_mode_out, .one_wire_mode_out,
    .pin_one_value_out, .core_error_out, .running_out);

  host_master_model host_u (.core_clk_in, .frame_in(frame),
    .byte_in(byte_val[7:0]), .select_n_out(shared_pin_two_in),
    .sdi_out(serial_data_pin_in));

  initial begin
    core_clk_in = 1'b0;
    forever #2.5 core_clk_in = !core_clk_in;
  end

  // Expected {analog_en, pin1_oe, pin2_oe, spi} for a combination number
  function automatic logic [3:0] pins(input logic [4:0] c);
    int n;
    int k;
    n = (c == 5'h00 || c > last_config) ? 1 : c;
    if (n > last_i2c_config) return {(n - 19) / 3 == 1, 3'b101};
    k = (n - 1) % 6;
    return {(n - 1) / 6 == 1, k inside {1, 3, 4, 5}, k inside {2, 3, 5}, 1'b0};
  endfunction : pins

  function automatic logic [15:0] obs(input logic [3:0] s);
    case (s)
      4'h0: return {15'h0, running_out};
      4'h1: return {15'h0, core_error_out};
      4'h2: return {15'h0, spi_mode_out};
      4'h3: return {15'h0, one_wire_mode_out};
      4'h4: return {12'h0, main_analog_en_out, shared_pin_one_oe_out,
                    shared_pin_two_oe_out, spi_mode_out};
      4'h5: return {15'h0, serial_data_pin_oe_out};
      4'h6: return main_analog_out;
      4'h7: return {15'h0, shared_pin_one_out};
      4'h8: return {15'h0, spi_select_out};
      4'h9: return {15'h0, spi_data_in_out};
      4'ha: return pin_one_value_out;
      4'hb: return {15'h0, shared_pin_two_out};
      default: return {14'h0, main_pin_pulse_out, serial_data_pin_out};
    endcase
  endfunction : obs

  task automatic chk(input logic [3:0] s, input logic [15:0] e);
    notes.push_back({s, e});
    ->look;
  endtask : chk

  // Reset, load random inputs, end clear; returns two edges after clear
  task automatic start(input logic [4:0] c, input logic w, input logic ok);
    rst_in = 1'b1;
    power_on_clear_in = 1'b1;
    pin_config_in = c;
    start_window_en_in = w;
    stored_signature_in = $urandom;
    config_checksum_in = ok ? stored_signature_in : ~stored_signature_in;
    {coef_offset_in, coef_gain_in} = $urandom;
    {coef_sq_in, coef_cube_in} = $urandom;
    {coef_t1_in, coef_t2_in} = $urandom;
    {bridge_raw_in, temp1_raw_in} = $urandom;
    {temp2_raw_in, alarm_one_level_in} = $urandom;
    {alarm_two_level_in, main_source_in, pin_one_source_in} = $urandom;
    {i2c_data_out_in, sample_valid_in, first_pulse_width_output_in,
     second_pulse_width_output_in, byte_val} = $urandom;
    repeat (3) @(negedge core_clk_in);
    rst_in = 1'b0;
    repeat (2) @(negedge core_clk_in);
    power_on_clear_in = 1'b0;
    repeat (2) @(negedge core_clk_in);
  endtask : start

  task automatic tally_and_finish();
    if (err_total == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : tally_and_finish

  // Result watcher: compares each note against the outputs
  initial begin
    forever begin
      @(look);
      while (notes.size() > 0) begin
        cur = notes.pop_front();
        samples_checked++;
        if (obs(cur.sel) !== cur.val) begin
          err_total++;
          $display("wrong value at %0t: got %h expected %h", $time,
                   obs(cur.sel), cur.val);
        end
      end
    end
  end

  initial begin
    #400000;
    err_total++;
    tally_and_finish();
  end

  initial begin
    void'($urandom(32'h1f632c62));
    {frame, use_ext_clock_in, one_wire_request_in, spi_active_in} = 4'h0;
    {spi_data_out_in, i2c_data_oe_in, ext_clock_ok_in} = 3'h3;
    high_diag_in = 1'b0;
    start(5'h13, 1'b0, 1'b1);
    chk(4'h0, 16'h0000);
    @(negedge core_clk_in);
    chk(4'h0, 16'h0001);
    chk(4'h1, 16'h0000);
    @(negedge core_clk_in);
    chk(4'h5, 16'h0000);
    spi_active_in = 1'b1;
    frame <= 1'b1;
    repeat (6) begin
      spi_data_out_in = $urandom;
      @(negedge core_clk_in);
      chk(4'h7, {15'h0, spi_data_out_in});
    end
    chk(4'h8, 16'h0000);
    chk(4'h9, {15'h0, byte_val[4]});
    frame <= 1'b0;
    spi_active_in = 1'b0;
    repeat (4) @(negedge core_clk_in);
    chk(4'h8, 16'h0001);
    chk(4'h9, {15'h0, !byte_val[2]});
    // External clock selected but not yet ready holds start-up
    use_ext_clock_in = 1'b1;
    ext_clock_ok_in = 1'b0;
    start(5'h07, 1'b0, 1'b1);
    repeat (3) @(negedge core_clk_in);
    chk(4'h0, 16'h0000);
    ext_clock_ok_in = 1'b1;
    repeat (3) @(negedge core_clk_in);
    chk(4'h0, 16'h0001);
    use_ext_clock_in = 1'b0;
    // Every combination number, plus illegal ones
    for (int c = 0; c < 32; c++) begin
      start(c[4:0], 1'b0, 1'b1);
      repeat (2) @(negedge core_clk_in);
      pe = pins(c[4:0]);
      chk(4'h4, {12'h0, pe});
      chk(4'h5, {15'h0, !pe[0]});
      pw = second_pulse_width_output_in && (c inside {[13:18], [25:27]});
      chk(4'hc, {14'h0, pw, i2c_data_out_in});
    end
    // Offset, half gain and first-order temperature term on fixed inputs
    start(5'h0a, 1'b0, 1'b1);
    {coef_sq_in, coef_cube_in, coef_t2_in} = 48'h0;
    {coef_gain_in, coef_t1_in} = 32'h80008000;
    sample_valid_in = 1'b1; // Take a corrected sample on every cycle while running
    ev[0] = coef_offset_in +
            16'((17'(bridge_raw_in) + 17'(temp1_raw_in)) >> 1);
    ev[1] = coef_offset_in + (temp1_raw_in >> 1);
    ev[2] = coef_offset_in + (temp2_raw_in >> 1);
    ev[3] = {16{ev[0] > alarm_one_level_in}};
    repeat (3) @(negedge core_clk_in);
    chk(4'h6, ev[main_source_in]);
    chk(4'ha, ev[pin_one_source_in]);
    chk(4'h7, {15'h0, ev[3][0]});
    chk(4'hb, {15'h0, ev[0] > alarm_two_level_in});
    // Signature mismatch forces error and diagnostic level
    high_diag_in = $urandom;
    start(5'h07, 1'b0, 1'b0);
    @(negedge core_clk_in);
    chk(4'h1, 16'h0001);
    chk(4'h0, 16'h0000);
    @(negedge core_clk_in);
    chk(4'h6, high_diag_in ? diag_high : diag_low);
    // Start window without and with a request
    start(5'h13, 1'b1, 1'b1);
    @(negedge core_clk_in);
    chk(4'h3, 16'h0001);
    repeat (9) @(negedge core_clk_in);
    chk(4'h0, 16'h0000);
    @(negedge core_clk_in);
    chk(4'h0, 16'h0001);
    chk(4'h2, 16'h0001);
    start(5'h13, 1'b1, 1'b1);
    one_wire_request_in = 1'b1;
    repeat (2) @(negedge core_clk_in);
    one_wire_request_in = 1'b0;
    repeat (20) @(negedge core_clk_in);
    chk(4'h3, 16'h0001);
    chk(4'h0, 16'h0000);
    @(negedge core_clk_in);
    tally_and_finish();
  end
endmodule : output_pin_sharing_and_safety_tb

bind output_pin_sharing_and_safety pin_share_properties chk_u (
  .core_clk_in, .rst_in, .power_on_clear_in, .high_diag_in, .spi_active_in,
  .spi_data_out_in, .shared_pin_one_out, .shared_pin_two_oe_out,
  .serial_data_pin_oe_out, .main_analog_out, .main_analog_en_out,
  .spi_mode_out, .one_wire_mode_out, .core_error_out, .running_out);
